// ### design/pio_port.sv
// Parallel I/O ports with pin interrupts, an APB register slave and
// stop-mode retention of the pad controls.
// Assumes APB signals and pad levels are synchronous to clock.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module pio_port #(
    parameter int N_PORTS = 3,                              // Interrupt-capable ports
    parameter logic [pio_pkg::PIO_W-1:0] OUT_ONLY_MASK = '0 // Output-only pins
) (
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pio_pkg::PIO_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pin side
    input wire pio_pkg::pio_pad_in_s [N_PORTS-1:0] pad_in,
    output pio_pkg::pio_pad_out_s [N_PORTS-1:0] pad_out,
    output logic [N_PORTS-1:0] port_irq_req,
    // Power management
    input wire logic stop_hold,
    input wire logic stop2_recover,
    output logic partial_powerdown_sel
);

    localparam int W = pio_pkg::PIO_W;

    // Pin is asserted for its polarity: 1 high/rising, 0 low/falling
    function automatic logic [W-1:0] asserted_lvl(input logic [W-1:0] lvl, input logic [W-1:0] pol);
        asserted_lvl = ~(lvl ^ pol);
    endfunction

    // Software-visible state
    logic [N_PORTS-1:0][W-1:0] data_r;
    logic [N_PORTS-1:0][W-1:0] pin_direction_r;
    logic [N_PORTS-1:0][W-1:0] pull_enable_r;
    logic [N_PORTS-1:0][W-1:0] slew_limit_r;
    logic [N_PORTS-1:0][W-1:0] high_drive_r;
    logic [N_PORTS-1:0][W-1:0] irq_pin_select_r;
    logic [N_PORTS-1:0][W-1:0] irq_polarity_r;
    logic [N_PORTS-1:0] irq_detect_mode_r;
    logic [N_PORTS-1:0] port_irq_enable_r;
    logic [N_PORTS-1:0] port_irq_flag_r;
    logic powerdown_recovered_r;
    logic ppd_ctrl_r;
    logic ppd_written_r;
    // Edge detector history: pin was selected and deasserted last cycle
    logic [N_PORTS-1:0][W-1:0] seen_deasserted_r;
    // Bus answer
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic err_nxt;
    // Decoded address
    logic [1:0] port_idx;
    logic [2:0] reg_idx;
    logic port_hit;
    logic pwr_hit;
    logic wr_en;
    // Per-port combinational terms and the registered pad controls
    logic [N_PORTS-1:0][W-1:0] in_buf_en;
    logic [N_PORTS-1:0][W-1:0] in_level;
    logic [N_PORTS-1:0][W-1:0] pin_asserted;
    logic [N_PORTS-1:0][W-1:0] oe_nxt;
    logic [N_PORTS-1:0] irq_set;
    logic [N_PORTS-1:0] irq_ack;
    pio_pkg::pio_pad_out_s [N_PORTS-1:0] pad_nxt;
    pio_pkg::pio_pad_out_s [N_PORTS-1:0] pad_r;

    // Address decode
    assign port_idx = paddr[pio_pkg::ADDR_PORT_LSB +: 2];
    assign reg_idx = paddr[pio_pkg::ADDR_REG_LSB +: 3];
    assign port_hit = !paddr[pio_pkg::ADDR_GLOBAL_BIT] && (int'(port_idx) < N_PORTS) && (paddr[1:0] == 2'h0);
    assign pwr_hit = (paddr == pio_pkg::ADDR_PWR_MGMT);
    // Writes land on the edge where the master sees pready high
    assign wr_en = psel && penable && pready_r && pwrite;

    // Pad control terms for every pin
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            // Input buffer off for analog pins and output-only pins
            in_buf_en[p] = ~pad_in[p].ana_en & ~OUT_ONLY_MASK;
            // Disabled input buffer reads as 0
            in_level[p] = pad_in[p].level & in_buf_en[p];
            pin_asserted[p] = asserted_lvl(in_level[p], irq_polarity_r[p]);
            // Analog first, then shared digital, then direction bit
            oe_nxt[p] = ~pad_in[p].ana_en & ((pad_in[p].dig_en & pad_in[p].dig_oe) |
                        (~pad_in[p].dig_en & pin_direction_r[p]));
            pad_nxt[p].oe = oe_nxt[p];
            pad_nxt[p].out = (pad_in[p].dig_en & pad_in[p].dig_out) | (~pad_in[p].dig_en & data_r[p]);
            pad_nxt[p].ie = in_buf_en[p];
            // Pull forced off for any driven or analog pin
            pad_nxt[p].pull_en = pull_enable_r[p] & ~oe_nxt[p] & ~pad_in[p].ana_en;
            // Interrupt pins take pull direction from polarity
            pad_nxt[p].pull_dn = irq_pin_select_r[p] & irq_polarity_r[p];
            // Slew and drive only matter while driving
            pad_nxt[p].slew_en = slew_limit_r[p] & oe_nxt[p];
            pad_nxt[p].high_drv = high_drive_r[p] & oe_nxt[p];
        end
    end

    // Pad controls; frozen while stopped so pins keep pre-stop state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pad_r <= '0;
        end else if (!stop_hold) begin
            pad_r <= pad_nxt;
        end
    end

    // Port data latch; written regardless of direction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            data_r <= {N_PORTS{{W{pio_pkg::RST_DATA}}}};
        end else if (wr_en && port_hit && reg_idx == pio_pkg::REG_DATA) begin
            data_r[port_idx] <= pwdata[W-1:0];
        end
    end

    // Pin configuration registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_direction_r <= {N_PORTS{{W{pio_pkg::RST_DIR}}}};
            pull_enable_r <= {N_PORTS{{W{pio_pkg::RST_PULL}}}};
            slew_limit_r <= {N_PORTS{{W{pio_pkg::RST_SLEW}}}};
            high_drive_r <= {N_PORTS{{W{pio_pkg::RST_DRIVE}}}};
            irq_pin_select_r <= '0;
            irq_polarity_r <= '0;
        end else if (wr_en && port_hit) begin
            // One register per index; the index already chose the port
            if (reg_idx == pio_pkg::REG_DIR) begin
                pin_direction_r[port_idx] <= pwdata[W-1:0];
            end else if (reg_idx == pio_pkg::REG_PULL) begin
                pull_enable_r[port_idx] <= pwdata[W-1:0];
            end else if (reg_idx == pio_pkg::REG_SLEW) begin
                slew_limit_r[port_idx] <= pwdata[W-1:0];
            end else if (reg_idx == pio_pkg::REG_DRIVE) begin
                high_drive_r[port_idx] <= pwdata[W-1:0];
            end else if (reg_idx == pio_pkg::REG_IRQ_SEL) begin
                irq_pin_select_r[port_idx] <= pwdata[W-1:0];
            end else if (reg_idx == pio_pkg::REG_POLARITY) begin
                irq_polarity_r[port_idx] <= pwdata[W-1:0];
            end
        end
    end

    // Mode and enable bits of the status/control register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_detect_mode_r <= '0;
            port_irq_enable_r <= '0;
        end else if (wr_en && port_hit && reg_idx == pio_pkg::REG_IRQ_SC) begin
            irq_detect_mode_r[port_idx] <= pwdata[pio_pkg::SC_MODE_BIT];
            port_irq_enable_r[port_idx] <= pwdata[pio_pkg::SC_IE_BIT];
        end
    end

    // Edge history: only a selected, deasserted pin arms the detector
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seen_deasserted_r <= '0;
        end else begin
            for (int p = 0; p < N_PORTS; p++) begin
                seen_deasserted_r[p] <= irq_pin_select_r[p] & ~pin_asserted[p];
            end
        end
    end

    // Flag set and acknowledge terms per port
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            // Deasserted last cycle, asserted now, on a selected pin; in level mode, any selected pin asserted now
            irq_set[p] = |(seen_deasserted_r[p] & irq_pin_select_r[p] & pin_asserted[p]) ||
                         (irq_detect_mode_r[p] && |(irq_pin_select_r[p] & pin_asserted[p]));
            // Level mode refuses the clear while any selected pin is asserted
            irq_ack[p] = wr_en && port_hit && (int'(port_idx) == p) && reg_idx == pio_pkg::REG_IRQ_SC &&
                         pwdata[pio_pkg::SC_ACK_BIT] &&
                         (!irq_detect_mode_r[p] || !(|(irq_pin_select_r[p] & pin_asserted[p])));
        end
    end

    // Interrupt flags: a new event wins over a same-cycle acknowledge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            port_irq_flag_r <= '0;
        end else begin
            for (int p = 0; p < N_PORTS; p++) begin
                if (irq_set[p]) begin
                    port_irq_flag_r[p] <= 1'b1;
                end else if (irq_ack[p]) begin
                    port_irq_flag_r[p] <= 1'b0;
                end
            end
        end
    end

    // Request stays up until the flag clears or the enable drops
    logic [N_PORTS-1:0] irq_req_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_req_r <= '0;
        end else begin
            irq_req_r <= port_irq_flag_r & port_irq_enable_r;
        end
    end

    // Power management: write-once stop2 select, recovery flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ppd_ctrl_r <= 1'b0;
            ppd_written_r <= 1'b0;
        end else if (wr_en && pwr_hit && !ppd_written_r) begin
            ppd_ctrl_r <= pwdata[pio_pkg::PWR_PPD_CTRL_BIT];
            ppd_written_r <= 1'b1;
        end
    end

    // Recovery flag: recovery event wins over the acknowledge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            powerdown_recovered_r <= 1'b0;
        end else if (stop2_recover) begin
            powerdown_recovered_r <= 1'b1;
        end else if (wr_en && pwr_hit && pwdata[pio_pkg::PWR_ACK_BIT]) begin
            powerdown_recovered_r <= 1'b0;
        end
    end

    // Read mux; upper bits and write-only bits read as zero
    always_comb begin
        rd_nxt = '0;
        err_nxt = 1'b0;
        if (port_hit) begin
            if (reg_idx == pio_pkg::REG_DATA) begin
                // Outputs read the latch, inputs read the pin
                rd_nxt[W-1:0] = (pin_direction_r[port_idx] & data_r[port_idx]) |
                                (~pin_direction_r[port_idx] & in_level[port_idx]);
            end else if (reg_idx == pio_pkg::REG_DIR) begin
                rd_nxt[W-1:0] = pin_direction_r[port_idx];
            end else if (reg_idx == pio_pkg::REG_PULL) begin
                rd_nxt[W-1:0] = pull_enable_r[port_idx];
            end else if (reg_idx == pio_pkg::REG_SLEW) begin
                rd_nxt[W-1:0] = slew_limit_r[port_idx];
            end else if (reg_idx == pio_pkg::REG_DRIVE) begin
                rd_nxt[W-1:0] = high_drive_r[port_idx];
            end else if (reg_idx == pio_pkg::REG_IRQ_SEL) begin
                rd_nxt[W-1:0] = irq_pin_select_r[port_idx];
            end else if (reg_idx == pio_pkg::REG_POLARITY) begin
                rd_nxt[W-1:0] = irq_polarity_r[port_idx];
            end else begin
                // Acknowledge bit left at zero
                rd_nxt[pio_pkg::SC_FLAG_BIT] = port_irq_flag_r[port_idx];
                rd_nxt[pio_pkg::SC_IE_BIT] = port_irq_enable_r[port_idx];
                rd_nxt[pio_pkg::SC_MODE_BIT] = irq_detect_mode_r[port_idx];
            end
        end else if (pwr_hit) begin
            rd_nxt[pio_pkg::PWR_FLAG_BIT] = powerdown_recovered_r;
            rd_nxt[pio_pkg::PWR_PPD_CTRL_BIT] = ppd_ctrl_r;
        end else begin
            // Unmapped address: error, no state change
            err_nxt = 1'b1;
        end
    end

    // APB answer one cycle into the access phase, so outputs stay registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && err_nxt;
            if (psel && penable && !pready_r && !pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // Output wiring straight from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pad_out = pad_r;
    assign port_irq_req = irq_req_r;
    assign partial_powerdown_sel = ppd_ctrl_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Plain GPIO pin follows its direction bit one cycle later
    property p_dir_oe;
        !pad_in[0].ana_en[0] && !pad_in[0].dig_en[0] && !stop_hold |=> pad_out[0].oe[0] == $past(pin_direction_r[0][0]);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("oe does not follow direction");

    // Shared digital function owns the output enable
    property p_dig_oe;
        pad_in[0].dig_en[0] && !pad_in[0].ana_en[0] && !stop_hold |=> pad_out[0].oe[0] == $past(pad_in[0].dig_oe[0]);
    endproperty
    a_dig_oe: assert property (p_dig_oe) else $error("peripheral oe not applied");

    // Analog pin has both buffers off
    property p_analog_off;
        pad_in[0].ana_en[0] && !stop_hold |=> !pad_out[0].oe[0] && !pad_out[0].ie[0] && !pad_out[0].pull_en[0];
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog pin buffers active");

    // Driving pin never has its pull on
    property p_pull_off;
        pad_out[0].oe[0] |-> !pad_out[0].pull_en[0];
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull on while driving");

    // Rising edge on a selected pin sets the flag next cycle
    sequence s_low_then_high;
        irq_pin_select_r[1][0] && irq_polarity_r[1][0] && !in_level[1][0] ##1
        irq_pin_select_r[1][0] && irq_polarity_r[1][0] && in_level[1][0];
    endsequence
    property p_edge_sets;
        s_low_then_high |=> port_irq_flag_r[1];
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge missed");

    // Acknowledge in level mode is refused while a pin is asserted
    property p_level_hold;
        irq_detect_mode_r[2] && port_irq_flag_r[2] && |(irq_pin_select_r[2] & pin_asserted[2]) |=> port_irq_flag_r[2];
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("flag cleared while asserted");

    // Edge-mode acknowledge with no new event clears the flag
    property p_ack_clears;
        irq_ack[1] && !irq_set[1] && !irq_detect_mode_r[1] |=> !port_irq_flag_r[1];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("acknowledge failed");

    // Request follows flag AND enable with one cycle of latency
    property p_req;
        ##1 port_irq_req[1] == $past(port_irq_flag_r[1] && port_irq_enable_r[1]);
    endproperty
    a_req: assert property (p_req) else $error("request mismatch");

    // Stop freezes pad controls
    property p_stop_hold;
        stop_hold |=> $stable(pad_out[0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("pad changed in stop");

    // Power-down acknowledge clears the recovery flag
    property p_pwr_ack;
        wr_en && pwr_hit && pwdata[pio_pkg::PWR_ACK_BIT] && !stop2_recover |=> !powerdown_recovered_r;
    endproperty
    a_pwr_ack: assert property (p_pwr_ack) else $error("recovery flag not cleared");

    // Status read never shows the acknowledge bit
    property p_ack_reads_zero;
        pready && port_hit && reg_idx == pio_pkg::REG_IRQ_SC |-> !prdata[pio_pkg::SC_ACK_BIT];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("acknowledge read as one");

endmodule // pio_port

`default_nettype wire

// ### design/pio_pkg.sv
// Package for the parallel I/O port block: register map, field positions,
// reset values and the pin-side carrier structs.
// Assumes a 32-bit APB master and 8-pin ports.
`default_nettype none
package pio_pkg;

    // Pins per port and address width of the register window
    localparam int PIO_W = 8;
    localparam int PIO_AW = 8;

    // Per-port register index, taken from paddr[4:2]; ports step by 0x20
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_DIR = 3'h1;
    localparam logic [2:0] REG_PULL = 3'h2;
    localparam logic [2:0] REG_SLEW = 3'h3;
    localparam logic [2:0] REG_DRIVE = 3'h4;
    localparam logic [2:0] REG_IRQ_SEL = 3'h5;
    localparam logic [2:0] REG_POLARITY = 3'h6;
    localparam logic [2:0] REG_IRQ_SC = 3'h7;

    // Address field positions
    localparam int ADDR_REG_LSB = 2;
    localparam int ADDR_PORT_LSB = 5;
    localparam int ADDR_GLOBAL_BIT = 7;

    // Power management register, outside the port window
    localparam logic [PIO_AW-1:0] ADDR_PWR_MGMT = 8'h80;

    // Fields of irq_status_control_reg
    localparam int SC_MODE_BIT = 0;
    localparam int SC_IE_BIT = 1;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_FLAG_BIT = 3;

    // Fields of power_mgmt_status_control_two
    localparam int PWR_PPD_CTRL_BIT = 0;
    localparam int PWR_ACK_BIT = 2;
    localparam int PWR_FLAG_BIT = 3;

    // Reset values of one pin's control bits
    localparam logic RST_DIR = 1'b0;
    localparam logic RST_DATA = 1'b0;
    localparam logic RST_PULL = 1'b0;
    localparam logic RST_SLEW = 1'b1;
    localparam logic RST_DRIVE = 1'b0;

    // Pin side inputs of one port
    typedef struct packed {
        logic [PIO_W-1:0] level;    // Pad input level
        logic [PIO_W-1:0] dig_en;   // Shared digital function owns the pin
        logic [PIO_W-1:0] dig_oe;   // Output enable from that function
        logic [PIO_W-1:0] dig_out;  // Output data from that function
        logic [PIO_W-1:0] ana_en;   // Shared analog function owns the pin
    } pio_pad_in_s;

    // Pad controls of one port
    typedef struct packed {
        logic [PIO_W-1:0] out;      // Output data
        logic [PIO_W-1:0] oe;       // Output buffer enable
        logic [PIO_W-1:0] ie;       // Input buffer enable
        logic [PIO_W-1:0] pull_en;  // Pull device on
        logic [PIO_W-1:0] pull_dn;  // 1 pull-down, 0 pull-up
        logic [PIO_W-1:0] slew_en;  // Slew limiting on
        logic [PIO_W-1:0] high_drv; // High drive strength
    } pio_pad_out_s;

endpackage
`default_nettype wire

// ### tb/pio_pad_model.sv
// Pin-side model: outside circuitry on every pin of every port.
// Assumes the bench changes drive requests just after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module pio_pad_model #(
    parameter int N = 3 // Ports modelled
) (
    input wire logic clock,
    input wire logic [N-1:0][7:0] drv_en,
    input wire logic [N-1:0][7:0] drv_val,
    input wire pio_pkg::pio_pad_out_s [N-1:0] pad_out,
    output logic [N-1:0][7:0] level
);
    // Last level seen; a floating pin must not keep showing it
    logic [N-1:0][7:0] last_r = '0;
    always_ff @(posedge clock) begin
        last_r <= level;
    end
    // Outside driver first, then the device's own output, then its pull
    always_comb begin
        for (int p = 0; p < N; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (drv_en[p][b]) begin
                    level[p][b] = drv_val[p][b];
                end else if (pad_out[p].oe[b]) begin
                    level[p][b] = pad_out[p].out[b];
                end else if (pad_out[p].pull_en[b]) begin
                    level[p][b] = ~pad_out[p].pull_dn[b];
                end else begin
                    // Floating: toggle so no stale value passes for a level
                    level[p][b] = ~last_r[p][b];
                end
            end
        end
    end
endmodule // pio_pad_model
`default_nettype wire

// ### tb/pio_port_tb_top.sv
// Self-checking bench for pio_port: APB tasks and pin scenarios.
// Assumes pio_pad_model on the pin side of all three ports.
`timescale 1ns/1ps
`default_nettype none
module pio_port_tb_top;
    localparam int NP = 3;
    // Short aliases for the register indexes used most
    localparam logic [2:0] DAT = pio_pkg::REG_DATA, DIR = pio_pkg::REG_DIR;
    localparam logic [2:0] SC = pio_pkg::REG_IRQ_SC, SEL = pio_pkg::REG_IRQ_SEL, POL = pio_pkg::REG_POLARITY;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic stop_hold = 1'h0, stop2_recover = 1'h0;
    // Peripheral hand-over inputs and outside pin drivers
    logic [NP-1:0][7:0] dig_en = '0, dig_oe = '0, dig_out = '0, ana_en = '0, lvl;
    logic ppd_sel;
    logic [NP-1:0][7:0] drv_en = '1, drv_val = {8'h00, 8'h00, 8'hA5};
    pio_pkg::pio_pad_in_s [NP-1:0] pad_in;
    pio_pkg::pio_pad_out_s [NP-1:0] pad_out;
    logic [NP-1:0] irq;
    int n_fail = 0, compares = 0;
    always #5 clock = ~clock;
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            pad_in[p] = {lvl[p], dig_en[p], dig_oe[p], dig_out[p], ana_en[p]};
        end
    end
    pio_port #(.N_PORTS(NP)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .port_irq_req(irq),
        .stop_hold(stop_hold), .stop2_recover(stop2_recover), .partial_powerdown_sel(ppd_sel));
    pio_pad_model #(.N(NP)) pads (.clock(clock), .drv_en(drv_en), .drv_val(drv_val),
        .pad_out(pad_out), .level(lvl));
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // Pad-side results are eight bits wide
    task automatic pchk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        chk(nm, {24'h0, ex}, got === 8'hxx ? 32'hx : {24'h0, got});
    endtask
    // One APB transfer; the answer is taken at the edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] x,
        output logic e);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        x = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Let an edge pass so the next call never drives psel twice in one step
        @(posedge clock);
        if (n >= 20) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic wr(input logic [2:0] p, input logic [2:0] r, input logic [7:0] d);
        logic [31:0] x;
        logic e;
        apb(1'h1, {p, r, 2'h0}, d, x, e);
    endtask
    task automatic rd(input logic [2:0] p, input logic [2:0] r, input logic [7:0] ex, input string nm);
        logic [31:0] x;
        logic e;
        apb(1'h0, {p, r, 2'h0}, 8'h00, x, e);
        chk(nm, {24'h0, ex}, x);
    endtask
    initial begin
        logic [31:0] x;
        logic e;
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        // Reset state and input read-back
        rd(0, DIR, 8'h00, "dir");
        rd(0, pio_pkg::REG_SLEW, 8'hFF, "slew");
        rd(0, pio_pkg::REG_PULL, 8'h00, "pull");
        rd(0, DAT, 8'hA5, "data in");
        pchk("oe", 8'h00, pad_out[0].oe);
        $display("test reset done");
        // Mixed direction, gated slew, drive and pull
        wr(0, DAT, 8'h3C);
        drv_en[0] <= 8'h0F;
        wr(0, DIR, 8'hF0);
        wr(0, pio_pkg::REG_DRIVE, 8'hFF);
        wr(0, pio_pkg::REG_PULL, 8'hFF);
        repeat (2) @(posedge clock);
        rd(0, DAT, 8'h35, "data mix");
        pchk("oe", 8'hF0, pad_out[0].oe);
        pchk("out", 8'h30, pad_out[0].out & 8'hF0);
        pchk("drive", 8'hF0, pad_out[0].high_drv);
        pchk("slew", 8'hF0, pad_out[0].slew_en);
        pchk("pull", 8'h0F, pad_out[0].pull_en);
        pchk("ie", 8'hFF, pad_out[0].ie);
        // Pin 1 digital, pin 0 analog, pin 2 both
        ana_en[0] <= 8'h05;
        dig_en[0] <= 8'h06;
        dig_oe[0] <= 8'h06;
        dig_out[0] <= 8'h02;
        repeat (2) @(posedge clock);
        pchk("oe share", 8'hF2, pad_out[0].oe);
        pchk("out share", 8'h32, pad_out[0].out & 8'hF2);
        pchk("ie share", 8'hFA, pad_out[0].ie);
        pchk("pull share", 8'h08, pad_out[0].pull_en);
        rd(0, DAT, 8'h30, "data ana");
        ana_en[0] <= 8'h00;
        dig_en[0] <= 8'h00;
        $display("test pins done");
        // Edge mode on port 1, set up in the safe order
        wr(1, SC, 8'h00);
        wr(1, POL, 8'h01);
        wr(1, SEL, 8'h03);
        wr(1, SC, 8'h04);
        wr(1, SC, 8'h02);
        rd(1, SC, 8'h02, "sc quiet");
        drv_val[1] <= 8'h01;
        repeat (3) @(posedge clock);
        pchk("irq", 8'h01, {7'h0, irq[1]});
        rd(1, SC, 8'h0A, "sc rise");
        wr(1, SC, 8'h02);
        rd(1, SC, 8'h0A, "sc held");
        wr(1, SC, 8'h06);
        rd(1, SC, 8'h02, "sc ack");
        pchk("irq off", 8'h00, {7'h0, irq[1]});
        drv_val[1] <= 8'h11;
        repeat (2) @(posedge clock);
        drv_val[1] <= 8'h01;
        repeat (2) @(posedge clock);
        rd(1, SC, 8'h02, "sc unsel");
        drv_val[1] <= 8'h03;
        repeat (2) @(posedge clock);
        drv_val[1] <= 8'h01;
        repeat (2) @(posedge clock);
        rd(1, SC, 8'h0A, "sc fall");
        pchk("pull dn", 8'h01, pad_out[1].pull_dn);
        wr(1, SC, 8'h00);
        rd(1, SC, 8'h08, "sc masked");
        pchk("irq mask", 8'h00, {7'h0, irq[1]});
        $display("test edge done");
        // Level mode on port 2: ack refused while asserted
        wr(2, SEL, 8'h01);
        wr(2, SC, 8'h01);
        rd(2, SC, 8'h09, "lvl set");
        wr(2, SC, 8'h05);
        rd(2, SC, 8'h09, "lvl stuck");
        drv_val[2] <= 8'h01;
        wr(2, SC, 8'h05);
        rd(2, SC, 8'h01, "lvl clear");
        $display("test level done");
        // Unmapped port, recovery flag, stop freeze
        apb(1'h0, 8'h60, 8'h00, x, e);
        chk("slverr", 32'h1, {31'h0, e});
        stop2_recover <= 1'h1;
        @(posedge clock);
        stop2_recover <= 1'h0;
        apb(1'h0, pio_pkg::ADDR_PWR_MGMT, 8'h00, x, e);
        chk("ppd", 32'h8, x);
        apb(1'h1, pio_pkg::ADDR_PWR_MGMT, 8'h05, x, e);
        apb(1'h0, pio_pkg::ADDR_PWR_MGMT, 8'h00, x, e);
        chk("ppd ack", 32'h1, x);
        pchk("ppd sel", 8'h01, {7'h0, ppd_sel});
        stop_hold <= 1'h1;
        wr(0, DIR, 8'hFF);
        repeat (2) @(posedge clock);
        pchk("oe hold", 8'hF0, pad_out[0].oe);
        stop_hold <= 1'h0;
        repeat (2) @(posedge clock);
        pchk("oe run", 8'hFF, pad_out[0].oe);
        $display("test power done");
        close_out();
    end
endmodule // pio_port_tb_top
`default_nettype wire
